// File: rtl/gpbc_ctrl.sv
/*
 * One I/O controller: output-value and direction registers.
 * Assumes write strobes are one-cycle pulses from the bus slave.
 */
`timescale 1ns/1ps
module gpbc_ctrl #(
    parameter logic [31:0] IO_MASK = 32'h1FFF_FFFF
) (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  gpbc_pkg::gpbc_wr_t     wr_in,
    output logic [31:0]            out_val_out,
    output logic [31:0]            dir_out
);
    import gpbc_pkg::*;

    logic [DATA_W-1:0] pin_output_value;
    logic [DATA_W-1:0] pin_direction;
    logic [DATA_W-1:0] next_pin_output_value;
    logic [DATA_W-1:0] next_pin_direction;

    // Bits beyond the controller's driving pins are never stored, so input-only
    // pins can never be turned into outputs.
    always_comb begin
        next_pin_output_value = pin_output_value;
        next_pin_direction    = pin_direction;
        if (wr_in.out_we) begin
            next_pin_output_value = gpbc_merge(pin_output_value, wr_in.dat, wr_in.sel,
                                               IO_MASK);
        end
        if (wr_in.dir_we) begin
            next_pin_direction = gpbc_merge(pin_direction, wr_in.dat, wr_in.sel,
                                            IO_MASK);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_output_value <= RST_OUT;
            pin_direction    <= RST_DIR;
        end else begin
            pin_output_value <= next_pin_output_value;
            pin_direction    <= next_pin_direction;
        end
    end

    assign out_val_out = pin_output_value;
    assign dir_out     = pin_direction;

endmodule : gpbc_ctrl

// File: rtl/gpbc_pkg.sv
/*
 * Shared constants, carrier types and helpers of the three-controller I/O bank.
 * Assumes a 32-bit classic Wishbone host and one 125 MHz clock.
 */
package gpbc_pkg;

    // ************************************************************
    // Widths and pin split
    // ************************************************************
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned BE_W     = 4;
    localparam int unsigned PIO_W    = 71;
    localparam int unsigned ONLY_W   = 14;
    localparam int unsigned C0_IO_W  = 29;
    localparam int unsigned C1_IO_W  = 29;
    localparam int unsigned C2_IO_W  = 13;
    localparam int unsigned C0_LO    = 0;
    localparam int unsigned C1_LO    = 29;
    localparam int unsigned C2_LO    = 58;

    localparam logic [DATA_W-1:0] C0_IO_MASK = 32'h1FFF_FFFF;
    localparam logic [DATA_W-1:0] C1_IO_MASK = 32'h1FFF_FFFF;
    localparam logic [DATA_W-1:0] C2_IO_MASK = 32'h0000_1FFF;

    // ************************************************************
    // Address map
    // ************************************************************
    localparam logic [DATA_W-1:0] WIN_MASK = 32'hFFFF_F000;
    localparam logic [DATA_W-1:0] C0_BASE  = 32'hFF70_8000;
    localparam logic [DATA_W-1:0] C1_BASE  = 32'hFF70_9000;
    localparam logic [DATA_W-1:0] C2_BASE  = 32'hFF70_A000;
    localparam logic [11:0]       OFS_OUT  = 12'h000;
    localparam logic [11:0]       OFS_DIR  = 12'h004;
    localparam logic [11:0]       OFS_LVL  = 12'h008;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [DATA_W-1:0] RST_OUT = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_DIR = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_DAT = 32'h0000_0000;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [DATA_W-1:0] adr;
        logic [DATA_W-1:0] dat;
        logic [BE_W-1:0]   sel;
        logic              we;
        logic              cyc;
        logic              stb;
    } gpbc_wb_req_t;

    typedef struct packed {
        logic              out_we;
        logic              dir_we;
        logic [DATA_W-1:0] dat;
        logic [BE_W-1:0]   sel;
    } gpbc_wr_t;

    // Byte-lane merge of a write into a register, limited to implemented bits.
    function automatic logic [DATA_W-1:0] gpbc_merge(input logic [DATA_W-1:0] old,
                                                     input logic [DATA_W-1:0] dat,
                                                     input logic [BE_W-1:0]   sel,
                                                     input logic [DATA_W-1:0] mask);
        logic [DATA_W-1:0] res;
        res = old;
        for (int i = 0; i < BE_W; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction : gpbc_merge

endpackage : gpbc_pkg

// File: rtl/gpbc_top.sv
/*
 * Bank of three I/O controllers behind one classic Wishbone slave.
 * Assumes pin inputs synchronous to SYS_CLK_IN; PIO_OE high means the pin is driven.
 */
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps

// Overview of operation
// - The first controller owns pins 28..0, the second 57..29 and the third 70..58.
// - The third controller also reads fourteen input-only pins that can never drive.
// - Each controller has a 32-bit output-value, direction and input-level register.
// - Direction bit n set to 1 makes pin n an output and 0 makes it an input.
// - Output-value bit n set to 1 drives pin n high and 0 drives it low.
// - Reading the input-level register returns the current level of each pin.
// - Each controller decodes a 4KB window and the third one starts at 0xFF70A000.
module gpbc_top (
    input  wire logic                        SYS_CLK_IN,
    input  wire logic                        RST_IN,
    input  wire logic [31:0]                 WB_ADR_IN,
    input  wire logic [31:0]                 WB_DAT_IN,
    input  wire logic [3:0]                  WB_SEL_IN,
    input  wire logic                        WB_WE_IN,
    input  wire logic                        WB_CYC_IN,
    input  wire logic                        WB_STB_IN,
    output logic                             WB_ACK_OUT,
    output logic [31:0]                      WB_DAT_OUT,
    input  wire logic [gpbc_pkg::PIO_W-1:0]  PIO_IN,
    output logic [gpbc_pkg::PIO_W-1:0]       PIO_OUT,
    output logic [gpbc_pkg::PIO_W-1:0]       PIO_OE,
    input  wire logic [gpbc_pkg::ONLY_W-1:0] INPUT_ONLY_PINS_IN
);
    import gpbc_pkg::*;

    // ************************************************************
    // Bus request and decode
    // ************************************************************
    gpbc_wb_req_t      req;
    gpbc_wr_t          wr0;
    gpbc_wr_t          wr1;
    gpbc_wr_t          wr2;
    logic              wr_stb;
    logic [2:0]        hit;
    logic [11:0]       ofs;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] c0_out;
    logic [DATA_W-1:0] c0_dir;
    logic [DATA_W-1:0] c1_out;
    logic [DATA_W-1:0] c1_dir;
    logic [DATA_W-1:0] c2_out;
    logic [DATA_W-1:0] c2_dir;
    logic [DATA_W-1:0] c0_lvl;
    logic [DATA_W-1:0] c1_lvl;
    logic [DATA_W-1:0] c2_lvl;

    assign req = '{adr: WB_ADR_IN, dat: WB_DAT_IN, sel: WB_SEL_IN,
                   we: WB_WE_IN, cyc: WB_CYC_IN, stb: WB_STB_IN};

    // Every controller answers only inside its own 4KB window.
    assign hit[0] = (WB_ADR_IN & WIN_MASK) == C0_BASE;
    assign hit[1] = (WB_ADR_IN & WIN_MASK) == C1_BASE;
    assign hit[2] = (WB_ADR_IN & WIN_MASK) == C2_BASE;
    assign ofs    = WB_ADR_IN[11:0];

    function automatic gpbc_wr_t mk_wr(input logic sel_ctrl);
        gpbc_wr_t w;
        w.out_we = wr_stb & sel_ctrl & (ofs == OFS_OUT);
        w.dir_we = wr_stb & sel_ctrl & (ofs == OFS_DIR);
        w.dat    = WB_DAT_IN;
        w.sel    = WB_SEL_IN;
        return w;
    endfunction : mk_wr

    // The level register is read-only; a write to it, or to an unmapped
    // address, is acknowledged and dropped so software never hangs the bus.
    // A process rather than continuous assignments, so that a change of the strobe,
    // offset or data read inside the function also re-evaluates the strobes.
    always_comb begin
        wr0 = mk_wr(hit[0]);
        wr1 = mk_wr(hit[1]);
        wr2 = mk_wr(hit[2]);
    end

    // ************************************************************
    // Controllers and pin split
    // ************************************************************
    gpbc_ctrl #(.IO_MASK(C0_IO_MASK)) u_first_io_controller (
        .clk_in      (SYS_CLK_IN),
        .rst_in      (RST_IN),
        .wr_in       (wr0),
        .out_val_out (c0_out),
        .dir_out     (c0_dir)
    );

    gpbc_ctrl #(.IO_MASK(C1_IO_MASK)) u_second_io_controller (
        .clk_in      (SYS_CLK_IN),
        .rst_in      (RST_IN),
        .wr_in       (wr1),
        .out_val_out (c1_out),
        .dir_out     (c1_dir)
    );

    gpbc_ctrl #(.IO_MASK(C2_IO_MASK)) u_third_io_controller (
        .clk_in      (SYS_CLK_IN),
        .rst_in      (RST_IN),
        .wr_in       (wr2),
        .out_val_out (c2_out),
        .dir_out     (c2_dir)
    );

    assign PIO_OUT = {c2_out[C2_IO_W-1:0], c1_out[C1_IO_W-1:0], c0_out[C0_IO_W-1:0]};
    assign PIO_OE  = {c2_dir[C2_IO_W-1:0], c1_dir[C1_IO_W-1:0], c0_dir[C0_IO_W-1:0]};

    // Levels are taken from the pads, so an output pin reads back what it drives.
    assign c0_lvl = {3'h0, PIO_IN[C1_LO-1:C0_LO]};
    assign c1_lvl = {3'h0, PIO_IN[C2_LO-1:C1_LO]};
    assign c2_lvl = {5'h00, INPUT_ONLY_PINS_IN, PIO_IN[PIO_W-1:C2_LO]};

    // ************************************************************
    // Read path and bus slave
    // ************************************************************
    function automatic logic [DATA_W-1:0] sel_reg(input logic [DATA_W-1:0] o,
                                                  input logic [DATA_W-1:0] d,
                                                  input logic [DATA_W-1:0] l);
        logic [DATA_W-1:0] r;
        r = RST_DAT;
        if (ofs == OFS_OUT) begin
            r = o;
        end else if (ofs == OFS_DIR) begin
            r = d;
        end else if (ofs == OFS_LVL) begin
            r = l;
        end
        return r;
    endfunction : sel_reg

    always_comb begin
        rd_data = RST_DAT;
        if (hit[0]) begin
            rd_data = sel_reg(c0_out, c0_dir, c0_lvl);
        end else if (hit[1]) begin
            rd_data = sel_reg(c1_out, c1_dir, c1_lvl);
        end else if (hit[2]) begin
            rd_data = sel_reg(c2_out, c2_dir, c2_lvl);
        end
    end

    gpbc_wb_slave u_wb_slave (
        .clk_in     (SYS_CLK_IN),
        .rst_in     (RST_IN),
        .req_in     (req),
        .rd_data_in (rd_data),
        .ack_out    (WB_ACK_OUT),
        .dat_out    (WB_DAT_OUT),
        .wr_stb_out (wr_stb)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);

    logic rd_take;
    assign rd_take = WB_CYC_IN & WB_STB_IN & ~WB_WE_IN & ~WB_ACK_OUT;

    chk_ack_one_shot: assert property (
        (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
        else $error("Ack not a single cycle after request.");

    chk_third_window: assert property (
        (wr_stb && WB_ADR_IN == (C2_BASE | 32'(OFS_OUT)) && WB_SEL_IN == 4'hF)
        |=> c2_out == ($past(WB_DAT_IN) & C2_IO_MASK))
        else $error("Third controller write at its base missed.");

    chk_dir_write: assert property (
        (wr_stb && WB_ADR_IN == (C0_BASE | 32'(OFS_DIR)) && WB_SEL_IN == 4'hF)
        |=> PIO_OE[C0_IO_W-1:0] == $past(WB_DAT_IN[C0_IO_W-1:0]))
        else $error("Direction write did not reach pin enables.");

    chk_undriven_in: assert property (
        !c1_dir[24] |-> !PIO_OE[53])
        else $error("Pin driven while set as input.");

    chk_out_level: assert property (
        (wr_stb && WB_ADR_IN == (C1_BASE | 32'(OFS_OUT)) && WB_SEL_IN[3])
        |=> PIO_OUT[C1_LO + 24] == $past(WB_DAT_IN[24]))
        else $error("Output value bit not driven to pin.");

    chk_only_inputs: assert property (
        c2_dir[DATA_W-1:C2_IO_W] == '0 && c2_out[DATA_W-1:C2_IO_W] == '0)
        else $error("Input-only pin became writable.");

    chk_level_read: assert property (
        (rd_take && WB_ADR_IN == (C1_BASE | 32'(OFS_LVL))) |=> WB_DAT_OUT == $past(c1_lvl))
        else $error("Level read returned wrong pin state.");

    chk_unmapped_zero: assert property (
        (rd_take && hit == 3'h0) |=> WB_DAT_OUT == 32'h0000_0000)
        else $error("Unmapped read not zero.");

    chk_pin_split: assert property (
        (rd_take && WB_ADR_IN == (C0_BASE | 32'(OFS_LVL)))
        |=> WB_DAT_OUT[C0_IO_W-1:0] == $past(PIO_IN[C0_IO_W-1:0]))
        else $error("First controller level read mis-mapped.");

    chk_level_wr_drop: assert property (
        (wr_stb && hit[2] && ofs == OFS_LVL) |=> $stable(c2_out) && $stable(c2_dir))
        else $error("Write to level register changed a register.");

    chk_split_isolated: assert property (
        (wr_stb && hit[0] && ofs == OFS_OUT) |=> $stable(c1_out) && $stable(c2_out))
        else $error("First controller write reached another controller.");

    chk_ack_idle: assert property (
        (!(WB_CYC_IN && WB_STB_IN) && !WB_ACK_OUT) |=> !WB_ACK_OUT)
        else $error("Ack given without a request.");

endmodule : gpbc_top

// File: rtl/gpbc_wb_slave.sv
/*
 * Classic Wishbone handshake: one registered ack per request, registered read data.
 * Assumes the master holds its request until it samples ack.
 */
`timescale 1ns/1ps
module gpbc_wb_slave (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  gpbc_pkg::gpbc_wb_req_t req_in,
    input  wire logic [31:0]       rd_data_in,
    output logic                   ack_out,
    output logic [31:0]            dat_out,
    output logic                   wr_stb_out
);
    import gpbc_pkg::*;

    logic              ack;
    logic [DATA_W-1:0] dat;
    logic              next_ack;
    logic [DATA_W-1:0] next_dat;
    logic              take;

    // Ack is withheld for one cycle after it is given, so a held request is
    // never taken twice.
    assign take = req_in.cyc & req_in.stb & ~ack;

    always_comb begin
        next_ack = take;
        next_dat = dat;
        if (take & ~req_in.we) begin
            next_dat = rd_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack <= 1'b0;
            dat <= RST_DAT;
        end else begin
            ack <= next_ack;
            dat <= next_dat;
        end
    end

    assign ack_out    = ack;
    assign dat_out    = dat;
    assign wr_stb_out = take & req_in.we;

endmodule : gpbc_wb_slave

// File: test/gpbc_pins_model.sv
/*
 * Board side of the I/O bank: LEDs that read back what is driven, buttons on the rest.
 * Assumes the bench sets the button levels with nonblocking assignments at the sampling edge of the clock.
 */
`timescale 1ns/1ps
module gpbc_pins_model (
    input  wire logic [gpbc_pkg::PIO_W-1:0] pio_out_in,
    input  wire logic [gpbc_pkg::PIO_W-1:0] pio_oe_in,
    input  wire logic [gpbc_pkg::PIO_W-1:0] key_in,
    output logic [gpbc_pkg::PIO_W-1:0]      pio_in_out
);
    import gpbc_pkg::*;
    // ************************************************************
    // Pad level
    // ************************************************************
    // A driven pad shows the driven level, an undriven one the button level.
    always_comb begin
        pio_in_out = (pio_oe_in & pio_out_in) | (~pio_oe_in & key_in);
    end
endmodule : gpbc_pins_model

// File: test/gpbc_top_tb_top.sv
/*
 * Self-checking bench of the I/O bank with a behavioural register model.
 * Assumes the design package and the board-side pin model are compiled first.
 */
`timescale 1ns/1ps
module gpbc_top_tb_top;
    import gpbc_pkg::*;
    logic              clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic [31:0]       adr = '0, wdat = '0, q, e;
    logic [3:0]        sel = '0, ws;
    logic              ack;
    logic [31:0]       rdat;
    logic [PIO_W-1:0]  pio_in, pio_out, pio_oe, keys = '0, eo, ee;
    logic [ONLY_W-1:0] only = '0;
    logic [31:0]       m_out [3], m_dir [3];
    int                n_fail = 0, tests_run = 0, seed = 97661, cycles = 0, c, r;
    // ************************************************************
    // Design, board and clock
    // ************************************************************
    gpbc_top i_dut (.SYS_CLK_IN(clk), .RST_IN(rst), .WB_ADR_IN(adr), .WB_DAT_IN(wdat),
        .WB_SEL_IN(sel), .WB_WE_IN(we), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_ACK_OUT(ack),
        .WB_DAT_OUT(rdat), .PIO_IN(pio_in), .PIO_OUT(pio_out), .PIO_OE(pio_oe),
        .INPUT_ONLY_PINS_IN(only));
    gpbc_pins_model i_pins (.pio_out_in(pio_out), .pio_oe_in(pio_oe), .key_in(keys),
        .pio_in_out(pio_in));
    initial begin
        forever #4 clk = ~clk;
    end
    // The limit is far above the fewer than a thousand cycles that the sequence needs.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            summarize();
        end
    end
    // ************************************************************
    // Model helpers
    // ************************************************************
    function automatic logic [31:0] base_of(input int k);
        return (k == 0) ? 32'hFF70_8000 : (k == 1) ? 32'hFF70_9000 : 32'hFF70_A000;
    endfunction : base_of
    function automatic int width_of(input int k);
        return (k == 2) ? 13 : 29;
    endfunction : width_of
    function automatic logic [31:0] exp_lvl(input int k);
        logic [31:0] v;
        v = '0;
        for (int i = 0; i < 32; i++) begin
            if (i < width_of(k)) begin
                v[i] = m_dir[k][i] ? m_out[k][i] : keys[k * 29 + i];
            end else if (k == 2 && i >= 13 && i < 27) begin
                v[i] = only[i - 13];
            end
        end
        return v;
    endfunction : exp_lvl
    // ************************************************************
    // Bus cycle and compares
    // ************************************************************
    // Ack is sampled at the rising edge before its own update lands, and the read
    // data standing with it is taken at that same edge, so nothing races.
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rq);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        @(posedge clk);
        while (ack !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            n_fail++;
            $display("ERROR wb_ack expected 1 seen %b", ack);
        end
        rq = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb
    task automatic cmp_word(input string nm, input logic [31:0] ex, input logic [31:0] got);
        tests_run++;
        if (got !== ex) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp_word
    task automatic cmp_pins();
        int k;
        for (int p = 0; p < PIO_W; p++) begin
            k = (p < 29) ? 0 : (p < 58) ? 1 : 2;
            ee[p] = m_dir[k][p - k * 29];
            eo[p] = m_dir[k][p - k * 29] & m_out[k][p - k * 29];
        end
        @(negedge clk);
        tests_run++;
        if (pio_oe !== ee || (pio_out & pio_oe) !== eo) begin
            n_fail++;
            $display("ERROR pins expected %h/%h seen %h/%h", ee, eo, pio_oe, pio_out & pio_oe);
        end
    endtask : cmp_pins
    task automatic summarize();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        for (int k = 0; k < 3; k++) begin
            m_out[k] = RST_OUT;
            m_dir[k] = RST_DIR;
        end
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        keys <= PIO_W'({$random(seed), $random(seed), $random(seed)});
        only <= ONLY_W'($random(seed));
        cmp_pins();
        for (int k = 0; k < 3; k++) begin
            wb(1'b0, base_of(k), '0, 4'hF, q);
            cmp_word("out_reset", m_out[k], q);
            wb(1'b0, base_of(k) + 4, '0, 4'hF, q);
            cmp_word("dir_reset", m_dir[k], q);
            wb(1'b0, base_of(k) + 8, '0, 4'hF, q);
            cmp_word("lvl_reset", exp_lvl(k), q);
        end
        // Full-word writes to every controller before the random mix.
        for (int k = 0; k < 3; k++) begin
            e = $random(seed);
            wb(1'b1, base_of(k), e, 4'hF, q);
            m_out[k] = e & ((32'h1 << width_of(k)) - 1);
            e = $random(seed);
            wb(1'b1, base_of(k) + 4, e, 4'hF, q);
            m_dir[k] = e & ((32'h1 << width_of(k)) - 1);
            wb(1'b0, base_of(k), '0, 4'hF, q);
            cmp_word("out_full", m_out[k], q);
            wb(1'b0, base_of(k) + 4, '0, 4'hF, q);
            cmp_word("dir_full", m_dir[k], q);
            cmp_pins();
            wb(1'b0, base_of(k) + 8, '0, 4'hF, q);
            cmp_word("lvl_full", exp_lvl(k), q);
        end
        for (int t = 0; t < 40; t++) begin
            c = $unsigned($random(seed)) % 3;
            r = $unsigned($random(seed)) % 2;
            e = $random(seed);
            ws = (t % 4 == 0) ? 4'hF : 4'($random(seed));
            wb(1'b1, base_of(c) + 4 * r, e, ws, q);
            for (int b = 0; b < 4; b++) begin
                if (ws[b] && r == 0) m_out[c][b * 8 +: 8] = e[b * 8 +: 8];
                if (ws[b] && r == 1) m_dir[c][b * 8 +: 8] = e[b * 8 +: 8];
            end
            m_out[c] &= (32'h1 << width_of(c)) - 1;
            m_dir[c] &= (32'h1 << width_of(c)) - 1;
            wb(1'b0, base_of(c), '0, 4'hF, q);
            cmp_word("out_read", m_out[c], q);
            wb(1'b0, base_of(c) + 4, '0, 4'hF, q);
            cmp_word("dir_read", m_dir[c], q);
            cmp_pins();
            @(posedge clk);
            keys <= PIO_W'({$random(seed), $random(seed), $random(seed)});
            only <= ONLY_W'($random(seed));
            wb(1'b0, base_of(c) + 8, '0, 4'hF, q);
            cmp_word("lvl_read", exp_lvl(c), q);
        end
        wb(1'b1, base_of(2) + 8, 32'hFFFF_FFFF, 4'hF, q);
        wb(1'b1, 32'hFF70_B004, 32'hFFFF_FFFF, 4'hF, q);
        wb(1'b0, 32'hFF70_B004, '0, 4'hF, q);
        cmp_word("unmapped_rd", 32'h0, q);
        wb(1'b0, base_of(2) + 12, '0, 4'hF, q);
        cmp_word("hole_rd", 32'h0, q);
        wb(1'b0, base_of(2) + 4, '0, 4'hF, q);
        cmp_word("dir_kept", m_dir[2], q);
        wb(1'b1, base_of(2) + 4, 32'hFFFF_FFFF, 4'hF, q);
        m_dir[2] = 32'h0000_1FFF;
        wb(1'b0, base_of(2) + 4, '0, 4'hF, q);
        cmp_word("dir_only", m_dir[2], q);
        cmp_pins();
        summarize();
    end
endmodule : gpbc_top_tb_top
